// File: rtl/spbg_channel.sv
// one pulse channel: edge counter, half-period timer and optional ramp
`timescale 1ns/1ps
module spbg_channel #(
  parameter int PINS = 16,
  parameter bit RAMP_OK = 1'b0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic start,
  input wire logic ramp,
  input wire logic stop,
  input wire logic [$clog2(PINS)-1:0] pin_sel,
  input wire logic [13:0] rate,
  input wire logic [13:0] ramp_start_rate,
  input wire logic [13:0] ramp_cruise_rate,
  input wire logic [13:0] ramp_slope,
  input wire logic [30:0] count,
  output logic step_q,
  output logic active_q,
  output logic [31:0] left_q,
  output logic [$clog2(PINS)-1:0] pin_q,
  output logic claim_q,
  output logic rejected_q
);
  localparam int PW = $clog2(PINS);
  // a one-pin build leaves no width for the pin index
  if (PINS < 2)
  begin : g_pins_chk
    $error("need at least two pins");
  end
  spbg_pkg::spbg_state_t st_q, st_d;
  logic [23:0] half_q, half_d, tmr_q, tmr_d;
  logic [31:0] left_d;
  logic [13:0] cur_q, cur_d, top_q, top_d, slope_q, slope_d;
  logic [24:0] acc_q, acc_d;
  logic ramp_q, ramp_d, step_d, active_d, claim_d, rejected_d;
  logic [PW-1:0] pin_d;
  logic [13:0] r;
  logic ok;

  function automatic logic [23:0] half_of(input logic [13:0] hz);
    logic [31:0] q;
    q = spbg_pkg::CLK_HZ / (32'(hz) * 32'd2);
    return (q == 32'd0) ? 24'h000001 : q[23:0];
  endfunction

  function automatic logic [13:0] clip(input logic [13:0] hz, input logic [13:0] hi);
    clip = (hz < spbg_pkg::RATE_MIN_HZ) ? spbg_pkg::RATE_MIN_HZ : (hz > hi) ? hi : hz;
  endfunction

  always_comb
  begin
    st_d = st_q;
    half_d = half_q;
    tmr_d = tmr_q;
    left_d = left_q;
    cur_d = cur_q;
    top_d = top_q;
    slope_d = slope_q;
    acc_d = acc_q;
    ramp_d = ramp_q;
    step_d = step_q;
    pin_d = pin_q;
    rejected_d = 1'b0;
    r = 14'h0000;
    ok = 1'b0;
    if (stop)
    begin
      st_d = spbg_pkg::SPBG_IDLE; // R6
      step_d = 1'b0;
      left_d = spbg_pkg::LEFT_RST;
    end
    else if (start && ramp && !RAMP_OK)
      rejected_d = 1'b1; // R12
    else if (start)
    begin
      // R16
      ok = (count != 31'h00000000);
      ramp_d = ramp;
      if (ramp)
      begin
        top_d = clip(ramp_cruise_rate, spbg_pkg::RAMP_MAX_HZ); // R14
        r = clip(ramp_start_rate, top_d); // R13
        slope_d = ramp_slope;
      end
      else
        r = clip(rate, spbg_pkg::STEP_MAX_HZ); // R2
      cur_d = r;
      acc_d = '0;
      half_d = half_of(r);
      tmr_d = half_of(r);
      left_d = {count, 1'b0}; // R7
      pin_d = pin_sel; // R3
      step_d = ok;
      st_d = ok ? spbg_pkg::SPBG_HIGH : spbg_pkg::SPBG_IDLE;
    end
    else if (st_q != spbg_pkg::SPBG_IDLE)
    begin
      // R5
      if (ramp_q && cur_q < top_q)
      begin
        // R13 slope is in Hz per second, added to the accumulator once per clock
        acc_d = acc_q + 25'(slope_q);
        if (acc_d >= 25'(spbg_pkg::CLK_HZ))
        begin
          acc_d = acc_d - 25'(spbg_pkg::CLK_HZ);
          cur_d = cur_q + 14'h0001;
          half_d = half_of(cur_d);
        end
      end
      if (tmr_q > 24'h000001)
        tmr_d = tmr_q - 24'h000001;
      else
      begin
        left_d = left_q - 32'h00000001; // R1
        tmr_d = half_d;
        if (st_q == spbg_pkg::SPBG_HIGH)
        begin
          step_d = 1'b0; // R15
          st_d = spbg_pkg::SPBG_LOW;
        end
        else if (left_q == 32'h00000001)
        begin
          step_d = 1'b0;
          st_d = spbg_pkg::SPBG_IDLE;
        end
        else
        begin
          step_d = 1'b1;
          st_d = spbg_pkg::SPBG_HIGH;
        end
      end
    end
    active_d = (st_d != spbg_pkg::SPBG_IDLE); // R8
    claim_d = active_d;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= spbg_pkg::SPBG_IDLE;
      half_q <= spbg_pkg::HALF_RST;
      tmr_q <= spbg_pkg::HALF_RST;
      left_q <= spbg_pkg::LEFT_RST;
      cur_q <= '0;
      top_q <= '0;
      slope_q <= '0;
      acc_q <= '0;
      ramp_q <= 1'b0;
      step_q <= 1'b0;
      pin_q <= '0;
      active_q <= 1'b0;
      claim_q <= 1'b0;
      rejected_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      half_q <= half_d;
      tmr_q <= tmr_d;
      left_q <= left_d;
      cur_q <= cur_d;
      top_q <= top_d;
      slope_q <= slope_d;
      acc_q <= acc_d;
      ramp_q <= ramp_d;
      step_q <= step_d;
      pin_q <= pin_d;
      active_q <= active_d;
      claim_q <= claim_d;
      rejected_q <= rejected_d;
    end
  end
endmodule // spbg_channel

// File: rtl/spbg_pkg.sv
// constants shared by the stepper pulse burst generator
// Contract
// R1: each channel emits exactly the requested pulse count, any value up to 2147483647 (31 bits).
// R2: fixed-rate mode accepts any pulse rate from 1 Hz to 15 kHz.
// R3: the step output can be routed to any general-purpose output pin.
// R4: starting a burst turns the chosen pin into an output, and it stays an output afterwards.
// R5: a started burst runs on its own until its count is used up or it is stopped.
// R6: a stop request ends that channel's pulse output at once.
// R7: the remaining readout gives twice the number of pulses still to come.
// R8: each channel's activity flag is 1 while it produces pulses and 0 otherwise.
// R9: while channel 0 runs, it holds the timer units of PWM outputs 3, 4 and 5.
// R10: while channel 1 runs, it holds the timer units of PWM outputs 6, 7 and 8.
// R11: the two-channel build runs both channels concurrently; the single-channel build has channel 0 only.
// R12: ramped mode exists on channel 0 only; a ramp request on another channel is rejected.
// R13: a ramp starts at the start rate and rises to the cruise rate at the set slope; start may not exceed cruise.
// R14: ramped mode accepts rates from 1 Hz to a cruise ceiling of 3.3 kHz.
// R15: each pulse is a square wave of about half a period high and half low, resting low when idle.
// R16: a new burst on an active channel drops the old count and restarts with the new settings.
package spbg_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CNT_W = 31;
  localparam logic [30:0] CNT_MAX = 31'h7fffffff;
  localparam int unsigned RATE_W = 14;
  localparam logic [13:0] RATE_MIN_HZ = 14'h0001;
  localparam logic [13:0] STEP_MAX_HZ = 14'h3a98;
  localparam logic [13:0] RAMP_MAX_HZ = 14'h0ce4;
  localparam int unsigned HALF_W = 24;
  localparam logic [23:0] HALF_RST = 24'h000000;
  localparam logic [31:0] LEFT_RST = 32'h00000000;
  typedef enum logic [1:0] {SPBG_IDLE, SPBG_HIGH, SPBG_LOW} spbg_state_t;
endpackage

// File: rtl/spbg_top.sv
// stepper pulse burst generator: channels, pin routing and timer claims
`timescale 1ns/1ps
module spbg_top #(
  parameter int PINS = 16,
  parameter int CHANNELS = 2
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [CHANNELS-1:0] burst_start,
  input wire logic [CHANNELS-1:0] burst_ramp,
  input wire logic [CHANNELS-1:0] burst_stop,
  input wire logic [CHANNELS*$clog2(PINS)-1:0] burst_pin,
  input wire logic [CHANNELS*14-1:0] burst_rate,
  input wire logic [13:0] ramp_start_rate,
  input wire logic [13:0] ramp_cruise_rate,
  input wire logic [13:0] ramp_slope,
  input wire logic [CHANNELS*31-1:0] burst_count,
  input wire logic [PINS-1:0] gpio_out_sw,
  input wire logic [PINS-1:0] gpio_oe_sw,
  output logic [PINS-1:0] gpio_out_q,
  output logic [PINS-1:0] gpio_oe_q,
  output logic [CHANNELS*32-1:0] pulses_left_q,
  output logic chan0_active_flag,
  output logic chan1_active_flag,
  output logic shared_timer_unit_a,
  output logic shared_timer_unit_d,
  output logic ramp_rejected_q
);
  localparam int PW = $clog2(PINS);
  if (CHANNELS < 1 || CHANNELS > 2)
  begin : g_chan_chk
    $error("one or two channels only");
  end
  logic [CHANNELS-1:0] step, act, claim, rej;
  logic [CHANNELS*PW-1:0] pin;
  logic [PINS-1:0] out_d, oe_d, made_q, made_d;
  logic rej_d;

  // R11
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      spbg_channel #(
        .PINS(PINS),
        .RAMP_OK(g == 0)
      ) u_ch (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(burst_start[g]),
        .ramp(burst_ramp[g]),
        .stop(burst_stop[g]),
        .pin_sel(burst_pin[g*PW +: PW]),
        .rate(burst_rate[g*14 +: 14]),
        .ramp_start_rate(ramp_start_rate),
        .ramp_cruise_rate(ramp_cruise_rate),
        .ramp_slope(ramp_slope),
        .count(burst_count[g*31 +: 31]),
        .step_q(step[g]),
        .active_q(act[g]),
        .left_q(pulses_left_q[g*32 +: 32]),
        .pin_q(pin[g*PW +: PW]),
        .claim_q(claim[g]),
        .rejected_q(rej[g])
      );
    end
  endgenerate

  always_comb
  begin
    made_d = made_q;
    out_d = gpio_out_sw;
    for (int c = 0; c < CHANNELS; c++)
    begin
      // a stopped, refused or empty start runs nothing, so it leaves the pin alone
      if (burst_start[c] && !burst_stop[c] && !(burst_ramp[c] && c != 0)
          && |burst_count[c*31 +: 31])
        made_d[burst_pin[c*PW +: PW]] = 1'b1; // R4
      if (act[c])
        out_d[pin[c*PW +: PW]] = step[c]; // R3
    end
    oe_d = gpio_oe_sw | made_d; // R4
    rej_d = |rej;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      made_q <= '0;
      gpio_out_q <= '0;
      gpio_oe_q <= '0;
      ramp_rejected_q <= 1'b0;
    end
    else
    begin
      made_q <= made_d;
      gpio_out_q <= out_d;
      gpio_oe_q <= oe_d;
      ramp_rejected_q <= rej_d; // R12
    end
  end

  // flags come straight from channel flops
  assign chan0_active_flag = act[0]; // R8
  assign shared_timer_unit_a = claim[0]; // R9
  generate
    if (CHANNELS > 1)
    begin : g_c1
      assign chan1_active_flag = act[1];
      assign shared_timer_unit_d = claim[1]; // R10
    end
    else
    begin : g_c0
      assign chan1_active_flag = 1'b0;
      assign shared_timer_unit_d = 1'b0;
    end
  endgenerate
endmodule // spbg_top

// File: tb/spbg_motor_drv.sv
// stepper driver stand-in: counts rising step edges on its input
`timescale 1ns/1ps
module spbg_motor_drv (
  input wire logic clk_sys,
  input wire logic step,
  output int pulses
);
  logic step_q = 1'b0;
  initial pulses = 0;
  always @(posedge clk_sys)
  begin
    if (step === 1'b1 && step_q !== 1'b1)
      pulses <= pulses + 1;
    step_q <= step;
  end
endmodule // spbg_motor_drv

// File: tb/spbg_top_chk.sv
// concurrent checks on the burst generator top ports
`timescale 1ns/1ps
module spbg_top_chk #(
  parameter int PINS = 16,
  parameter int CHANNELS = 2
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [CHANNELS-1:0] burst_start,
  input wire logic [CHANNELS-1:0] burst_ramp,
  input wire logic [CHANNELS-1:0] burst_stop,
  input wire logic [CHANNELS*31-1:0] burst_count,
  input wire logic [CHANNELS*32-1:0] pulses_left_q,
  input wire logic chan0_active_flag,
  input wire logic chan1_active_flag,
  input wire logic shared_timer_unit_a,
  input wire logic shared_timer_unit_d,
  input wire logic ramp_rejected_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  grp_a_a: assert property (shared_timer_unit_a == chan0_active_flag)
    else $error("group a claim off");
  grp_d_a: assert property (shared_timer_unit_d == chan1_active_flag)
    else $error("group d claim off");
  start0_a: assert property (burst_start[0] && !burst_stop[0] && |burst_count[30:0] |=>
    chan0_active_flag && pulses_left_q[31:0] == {$past(burst_count[30:0]), 1'b0})
    else $error("channel 0 start answer wrong");
  start1_a: assert property (burst_start[1] && !burst_stop[1] && !burst_ramp[1]
    && |burst_count[61:31] |=> chan1_active_flag && pulses_left_q[63:32] ==
    {$past(burst_count[61:31]), 1'b0}) else $error("channel 1 start answer wrong");
  stop0_a: assert property (burst_stop[0] |=> !chan0_active_flag)
    else $error("channel 0 kept running");
  ramp_refuse_a: assert property (burst_start[1] && burst_ramp[1] && !burst_stop[1]
    |-> ##2 ramp_rejected_q) else $error("ramp on channel 1 not refused");
  refuse_cause_a: assert property (ramp_rejected_q |->
    $past(burst_start[1] && burst_ramp[1] && !burst_stop[1], 2))
    else $error("refusal without cause");
  left_step_a: assert property ($past(chan0_active_flag && !burst_start[0] && !burst_stop[0])
    |-> $past(pulses_left_q[31:0]) - pulses_left_q[31:0] <= 32'h1)
    else $error("edge count jumped");
endmodule // spbg_top_chk

bind spbg_top spbg_top_chk #(.PINS(PINS), .CHANNELS(CHANNELS)) chk_u (.*);

// File: tb/stepper_pulse_burst_generator_test.sv
// self-checking bench for the stepper pulse burst generator
`timescale 1ns/1ps
module stepper_pulse_burst_generator_test;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] burst_start = 2'h0, burst_ramp = 2'h0, burst_stop = 2'h0;
  logic [7:0] burst_pin = 8'h0;
  logic [27:0] burst_rate = 28'h0;
  logic [13:0] ramp_start_rate = 14'h0, ramp_cruise_rate = 14'h0, ramp_slope = 14'h0;
  logic [61:0] burst_count = 62'h0;
  logic [15:0] gpio_out_sw = 16'h0, gpio_oe_sw = 16'h0, gpio_out_q, gpio_oe_q;
  logic [63:0] pulses_left_q;
  logic chan0_active_flag, chan1_active_flag, shared_timer_unit_a, shared_timer_unit_d;
  logic ramp_rejected_q;
  logic [3:0] pin0 = 4'h0, pin1 = 4'h8;
  logic [31:0] seed = 32'h6b631b5f, r;
  int pulses0, pulses1, fails = 0, total_checks = 0, c0, c1, p;
  int exp_left[2];
  time t0[2];
  spbg_top dut_u (.*);
  spbg_motor_drv drv0_u (.clk_sys(clk_sys), .step(gpio_out_q[pin0]), .pulses(pulses0));
  spbg_motor_drv drv1_u (.clk_sys(clk_sys), .step(gpio_out_q[pin1]), .pulses(pulses1));
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // rejected requests expect the previous readout, which is zero after a finished burst
  task automatic go(input int c, input logic rmp, input logic [13:0] rate, input int cnt,
                    input logic ok);
    @(posedge clk_sys);
    #2;
    burst_start[c] = 1'b1;
    burst_ramp[c] = rmp;
    burst_pin[c*4+:4] = c ? pin1 : pin0;
    burst_rate[c*14+:14] = rate;
    burst_count[c*31+:31] = cnt[30:0];
    exp_left[c] = ok ? 2 * cnt : 0;
    @(posedge clk_sys);
    #2;
    burst_start[c] = 1'b0;
    burst_ramp[c] = 1'b0;
    t0[c] = $time;
    @(posedge clk_sys);
    #2;
    chk("active flag", 32'(ok), c ? chan1_active_flag : chan0_active_flag);
    chk("pulses left", exp_left[c], pulses_left_q[c*32+:32]);
    chk("ramp refused", 32'(c == 1 && rmp), 32'(ramp_rejected_q));
  endtask
  task automatic done(input int c, input int cnt, input int rate, input int p0);
    int n;
    n = 0;
    while ((c ? chan1_active_flag : chan0_active_flag) !== 1'b0 && n < 40000)
    begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    chk("burst length", 32'(2 * cnt * (10000000 / rate)), 32'(($time - t0[c]) / 50));
    @(posedge clk_sys);
    #2;
    chk("step count", 32'(cnt), 32'((c ? pulses1 : pulses0) - p0));
    chk("left at end", 32'h0, pulses_left_q[c*32+:32]);
    chk("pin driven", 32'h1, 32'(gpio_oe_q[c ? pin1 : pin0]));
    chk("pin at rest", 32'h0, 32'(gpio_out_q[c ? pin1 : pin0]));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #4000000;
    fails++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #2;
    arst_n = 1'b1;
    r = rnd();
    pin0 = {1'b0, r[2:0]};
    pin1 = {1'b1, r[5:3]};
    c0 = 1 + int'(r[8:6]);
    c1 = 6 + int'(r[11:9]);
    go(0, 1'b0, 14'h3a98, c0, 1'b1);
    go(1, 1'b0, 14'h2710, c1, 1'b1);
    chk("timer group a", 32'h1, 32'(shared_timer_unit_a));
    chk("timer group d", 32'h1, 32'(shared_timer_unit_d));
    done(0, c0, 15000, 0);
    done(1, c1, 10000, 0);
    $display("test concurrent bursts done");
    go(0, 1'b0, 14'h3a98, 8, 1'b1);
    repeat (1000) @(posedge clk_sys);
    #2;
    burst_stop[0] = 1'b1;
    p = pulses0;
    @(posedge clk_sys);
    #2;
    burst_stop[0] = 1'b0;
    chk("stopped", 32'h0, 32'(chan0_active_flag));
    repeat (1500) @(posedge clk_sys);
    #2;
    chk("no more steps", 32'(p), 32'(pulses0));
    chk("timer group a free", 32'h0, 32'(shared_timer_unit_a));
    $display("test stop done");
    go(0, 1'b0, 14'h3a98, 5, 1'b1);
    repeat (700) @(posedge clk_sys);
    #2;
    p = pulses0;
    go(0, 1'b0, 14'h3a98, 2, 1'b1);
    done(0, 2, 15000, p);
    go(1, 1'b1, 14'h3a98, 3, 1'b0);
    $display("test restart and refusal done");
    // start at or above the ceiling clips to the 3300 Hz ceiling, as the cruise rate does, so the ramp has nothing to climb
    ramp_start_rate = 14'h0ce4 + 14'(r[17:12]);
    ramp_cruise_rate = 14'h1000;
    ramp_slope = r[31:18];
    p = pulses0;
    go(0, 1'b1, 14'h0, 2, 1'b1);
    done(0, 2, 3300, p);
    $display("test ramp done");
    r = rnd();
    gpio_out_sw = r[15:0];
    gpio_oe_sw = r[31:16];
    @(posedge clk_sys);
    #2;
    chk("pins follow software", 32'(r[15:0]), 32'(gpio_out_q));
    chk("pins made output", 32'(r[31:16] | (16'h1 << pin0) | (16'h1 << pin1)),
        32'(gpio_oe_q));
    $display("test software pins done");
    end_of_test();
  end
endmodule // stepper_pulse_burst_generator_test
